// ==== inc/srb_pkg.sv ====
package srb_pkg;
  localparam int NSLOT = 6;
  localparam int SLOT_W = 3;
  localparam int WORD_W = 31;
  localparam int DATA_W = 28;
  localparam int CODE_W = 10;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_W = WORD_W + SLOT_W + 2;
  localparam int INIT_BUFS_BOTH = 8;
  localparam int INIT_BUFS_ONE = 6;
  localparam int INIT_WORDS = 16;
  localparam int INIT_W = 16;
  localparam int PL_FC_LSB = 17;
  localparam int PL_ST_BIT = 16;
  localparam int NIB_LSB = 0;
  localparam int EXT_LSB = 4;
  localparam logic [CODE_W-1:0] FC_MANCH = 10'h1FC;
  localparam logic [CODE_W-1:0] FC_CRC = 10'h1F8;
  localparam logic [CODE_W-1:0] FC_PHY = 10'h1F1;
  localparam logic [CODE_W-1:0] FC_EMPTY = 10'h1F0;
  localparam logic [CODE_W-1:0] FC_STB = 10'h1F2;
  localparam logic [CODE_W-1:0] FC_SYNC = 10'h1F9;
  localparam logic [3:0] RK_DATA = 4'h1;
  localparam logic [3:0] RK_OT = 4'h2;
  localparam logic [3:0] RK_STG = 4'h3;
  localparam logic [3:0] RK_STB = 4'h4;
  localparam logic [3:0] RK_LEAK = 4'h5;
  localparam logic [3:0] RK_OPEN = 4'h6;
  localparam logic [3:0] RK_MANCH = 4'h7;
  localparam logic [3:0] RK_CRC = 4'h8;
  localparam logic [3:0] RK_SYNC = 4'h9;
  localparam logic [3:0] RK_EMPTY = 4'hA;
  localparam logic [3:0] RK_NONE = 4'hF;
  localparam logic [WORD_W-1:0] EMPTY_WORD = {11'h000, FC_EMPTY, 10'h000};

  typedef logic [NSLOT-1:0][WORD_W-1:0] srb_bufs_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_CHECK = 2'b10
  } srb_state_e;

  // Code sits at field bits 19..10, everything else zero
  function automatic logic [WORD_W-1:0] code_word(input logic [CODE_W-1:0] code);
    return {11'h000, code, 10'h000};
  endfunction

  function automatic srb_bufs_t push_word(input srb_bufs_t b, input logic [WORD_W-1:0] w);
    srb_bufs_t o;
    o = b;
    for (int i = NSLOT - 1; i > 0; i--) begin
      o[i] = b[i-1];
    end
    o[0] = w;
    return o;
  endfunction
endpackage

// ==== src/srb_fifo.sv ====
`timescale 1ns/1ns
module srb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } srb_fifo_s;
  srb_fifo_s r;
  srb_fifo_s n;
  logic push;
  logic pop;

  assign in_ready_o = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o = r.mem[r.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_i;
      n.wp = (r.wp == AW'(DEPTH - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH - 1)) ? '0 : r.rp + AW'(1);
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else if (clk_en_i) begin
      r <= n;
    end
  end
endmodule // srb_fifo

// ==== src/srb_fault_prio.sv ====
`timescale 1ns/1ns
module srb_fault_prio (
  input wire logic frame_i,
  input wire logic manch_i,
  input wire logic crc_i,
  input wire logic ot_i,
  input wire logic stg_i,
  input wire logic stb_i,
  input wire logic leak_i,
  input wire logic open_i,
  input wire logic sync_uv_i,
  output logic [3:0] rank_o,
  output logic [srb_pkg::CODE_W-1:0] code_o
);
  import srb_pkg::*;

  always_comb begin
    rank_o = RK_NONE;
    code_o = FC_EMPTY;
    if (frame_i && !manch_i && !crc_i) begin
      rank_o = RK_DATA;
    end else if (ot_i) begin
      rank_o = RK_OT;
      code_o = FC_PHY;
    end else if (stg_i) begin
      rank_o = RK_STG;
      code_o = FC_PHY;
    end else if (stb_i) begin
      rank_o = RK_STB;
      code_o = FC_STB;
    end else if (leak_i) begin
      rank_o = RK_LEAK;
      code_o = FC_PHY;
    end else if (open_i) begin
      rank_o = RK_OPEN;
      code_o = FC_PHY;
    end else if (frame_i && manch_i) begin
      rank_o = RK_MANCH;
      code_o = FC_MANCH;
    end else if (frame_i && crc_i) begin
      rank_o = RK_CRC;
      code_o = FC_CRC;
    end else if (sync_uv_i) begin
      rank_o = RK_SYNC;
      code_o = FC_SYNC;
    end else if (frame_i) begin
      rank_o = RK_EMPTY;
    end
  end
endmodule // srb_fault_prio

// ==== src/srb_rx_buffer.sv ====
`timescale 1ns/1ns
module srb_rx_buffer (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic clk_en_i,
  input wire logic sync_mode_i,
  input wire logic check_in_device_select_i,
  input wire logic [srb_pkg::NSLOT-1:0] slot_enable_i,
  input wire logic frame_valid_i,
  output logic frame_ready_o,
  input wire logic [srb_pkg::WORD_W-1:0] frame_data_i,
  input wire logic [srb_pkg::SLOT_W-1:0] frame_slot_i,
  input wire logic frame_manch_err_i,
  input wire logic frame_check_err_i,
  input wire logic ot_i,
  input wire logic stg_i,
  input wire logic stb_i,
  input wire logic leak_i,
  input wire logic open_i,
  input wire logic sync_uv_i,
  input wire logic fault_status_read_i,
  input wire logic rd_req_i,
  input wire logic [srb_pkg::SLOT_W-1:0] rd_idx_i,
  output logic rd_valid_o,
  output logic [srb_pkg::WORD_W-1:0] rd_data_o,
  input wire logic be_test_i,
  input wire logic be_flag_read_i,
  output logic buffer_empty_fault_flag_o,
  output logic global_status_o,
  output logic fifo_write_locked_flag_o,
  output logic irq_o,
  input wire logic init_capture_en_i,
  input wire logic frame20_i,
  input wire logic other_ch_init_en_i,
  input wire logic other_ch_init_done_i,
  output logic init_done_o,
  output logic init_data_rdy_o,
  input wire logic [2:0] init_rd_buf_i,
  input wire logic [3:0] init_rd_addr_i,
  output logic [srb_pkg::INIT_W-1:0] init_rd_data_o
);
  import srb_pkg::*;

  typedef struct packed {
    srb_bufs_t sbuf;
    logic lock;
    logic [SLOT_W-1:0] rcv_cnt;
    logic irq;
    logic be_flag;
    srb_state_e st;
    logic [SLOT_W-1:0] chk_idx;
    logic [3:0] hold_rk;
    logic [CODE_W-1:0] hold_code;
    logic [WORD_W-1:0] rd_data;
    logic rd_valid;
    logic [INIT_BUFS_BOTH-1:0][INIT_WORDS-1:0][INIT_W-1:0] imem;
    logic [INIT_BUFS_BOTH-1:0] iph;
    logic [INIT_BUFS_BOTH-1:0][3:0] iid;
    logic [INIT_BUFS_BOTH-1:0][5:0] iext;
    logic [INIT_BUFS_BOTH-1:0][INIT_WORDS-1:0] imap;
    logic [INIT_BUFS_BOTH-1:0][7:0] iexp;
    logic idone;
    logic irdy;
    logic [INIT_W-1:0] ird;
  } srb_rx_s;

  function automatic srb_rx_s rst_state();
    srb_rx_s s;
    s = '0;
    for (int i = 0; i < NSLOT; i++) begin
      s.sbuf[i] = EMPTY_WORD;
    end
    s.st = ST_IDLE;
    s.hold_rk = RK_NONE;
    s.hold_code = FC_EMPTY;
    return s;
  endfunction

  // Engaged sensor is complete once every expected block has landed
  function automatic logic init_complete(input logic [INIT_WORDS-1:0] map, input logic [7:0] exp);
    logic [INIT_WORDS-1:0] mask;
    mask = (exp >= 8'h10) ? 16'hFFFF : ((16'h0001 << exp[3:0]) - 16'h0001);
    if (map == '0) begin
      return 1'b1;
    end
    return map[1] && map[2] && ((map & mask) == mask);
  endfunction

  localparam srb_rx_s RX_RST = rst_state();

  srb_rx_s r;
  srb_rx_s n;
  logic [FIFO_W-1:0] fifo_in;
  logic [FIFO_W-1:0] fifo_out;
  logic fifo_valid;
  logic fifo_ready;
  logic fire;
  logic [WORD_W-1:0] fr_data;
  logic [SLOT_W-1:0] fr_slot;
  logic fr_manch;
  logic fr_crc;
  logic [3:0] fr_rk;
  logic [CODE_W-1:0] fr_code;
  logic [3:0] ch_rk;
  logic [CODE_W-1:0] ch_code;
  logic ch_evt;
  logic [WORD_W-1:0] store_word;
  logic all_empty;
  logic en_full;
  logic init_take;
  logic [2:0] init_fc;
  logic [3:0] init_lim;
  logic [3:0] init_addr;
  logic [INIT_BUFS_BOTH-1:0] init_ok;
  logic [INIT_W-1:0] pl;

  assign fifo_in = {frame_slot_i, frame_manch_err_i, frame_check_err_i, frame_data_i};
  assign {fr_slot, fr_manch, fr_crc, fr_data} = fifo_out;
  // Drain stalls while a read or its check owns the slots
  assign fifo_ready = (r.st == ST_IDLE) && !rd_req_i;
  assign fire = fifo_valid && fifo_ready && clk_en_i;

  srb_fifo #(
    .W(FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(frame_valid_i),
    .in_ready_o(frame_ready_o),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_ready),
    .out_data_o(fifo_out)
  );

  srb_fault_prio u_frame_prio (
    .frame_i(1'b1),
    .manch_i(fr_manch),
    .crc_i(fr_crc && check_in_device_select_i),
    .ot_i(ot_i),
    .stg_i(stg_i),
    .stb_i(stb_i),
    .leak_i(leak_i),
    .open_i(open_i),
    .sync_uv_i(sync_uv_i),
    .rank_o(fr_rk),
    .code_o(fr_code)
  );

  srb_fault_prio u_chan_prio (
    .frame_i(1'b0),
    .manch_i(1'b0),
    .crc_i(1'b0),
    .ot_i(ot_i),
    .stg_i(stg_i),
    .stb_i(stb_i),
    .leak_i(leak_i),
    .open_i(open_i),
    .sync_uv_i(sync_uv_i),
    .rank_o(ch_rk),
    .code_o(ch_code)
  );

  // Checked frames drop their check bits, unchecked ones pass whole
  always_comb begin
    if (fr_rk != RK_DATA) begin
      store_word = code_word(fr_code);
    end else if (check_in_device_select_i) begin
      store_word = {3'b000, fr_data[DATA_W-1:0]};
    end else begin
      store_word = fr_data;
    end
  end

  assign ch_evt = clk_en_i && (ch_rk < r.hold_rk);

  always_comb begin
    all_empty = 1'b1;
    en_full = (slot_enable_i != '0);
    for (int i = 0; i < NSLOT; i++) begin
      if (r.sbuf[i] != EMPTY_WORD) begin
        all_empty = 1'b0;
      end else if (slot_enable_i[i]) begin
        en_full = 1'b0;
      end
    end
  end

  assign pl = fr_data[INIT_W-1:0];
  assign init_fc = fr_data[PL_FC_LSB +: 3];
  assign init_lim = other_ch_init_en_i ? 4'(INIT_BUFS_BOTH) : 4'(INIT_BUFS_ONE);
  assign init_addr = r.iid[init_fc] - 4'h1;
  assign init_take = fire && init_capture_en_i && frame20_i && (fr_rk == RK_DATA)
                     && !fr_data[PL_ST_BIT] && ({1'b0, init_fc} < init_lim);

  genvar g;
  generate
    for (g = 0; g < INIT_BUFS_BOTH; g++) begin : g_init_ok
      assign init_ok[g] = init_complete(r.imap[g], r.iexp[g]);
    end
  endgenerate

  always_comb begin
    n = r;
    n.rd_valid = 1'b0;
    n.ird = r.imem[init_rd_buf_i][init_rd_addr_i];
    if (ch_evt) begin
      n.hold_rk = ch_rk;
      n.hold_code = ch_code;
      if (sync_mode_i) begin
        for (int i = 0; i < NSLOT; i++) begin
          n.sbuf[i] = code_word(ch_code);
        end
      end else if (!r.lock) begin
        n.sbuf = push_word(n.sbuf, code_word(ch_code));
        n.rcv_cnt = (r.rcv_cnt == SLOT_W'(NSLOT)) ? r.rcv_cnt : r.rcv_cnt + SLOT_W'(1);
      end
    end else if (fault_status_read_i) begin
      n.hold_rk = RK_NONE;
    end
    if (fire) begin
      if (sync_mode_i) begin
        if (fr_slot < SLOT_W'(NSLOT)) begin
          n.sbuf[fr_slot] = store_word;
        end
      end else if (!r.lock) begin
        n.sbuf = push_word(n.sbuf, store_word);
        n.rcv_cnt = (n.rcv_cnt == SLOT_W'(NSLOT)) ? n.rcv_cnt : n.rcv_cnt + SLOT_W'(1);
      end
    end
    if (sync_mode_i || all_empty) begin
      n.lock = 1'b0;
    end
    case (r.st)
      ST_IDLE: begin
        if (clk_en_i && rd_req_i && (rd_idx_i < SLOT_W'(NSLOT))) begin
          n.rd_data = r.sbuf[rd_idx_i];
          n.rd_valid = 1'b1;
          n.rcv_cnt = '0;
          if (r.sbuf[rd_idx_i] != EMPTY_WORD) begin
            if (!be_test_i) begin
              n.sbuf[rd_idx_i] = EMPTY_WORD;
            end
            if (!sync_mode_i) begin
              n.lock = 1'b1;
            end
            n.chk_idx = rd_idx_i;
            n.st = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        n.st = ST_IDLE;
      end
      default: begin
        n.st = ST_IDLE;
      end
    endcase
    if (be_flag_read_i) begin
      n.be_flag = 1'b0;
    end
    if ((r.st == ST_CHECK) && (r.sbuf[r.chk_idx] != EMPTY_WORD)) begin
      n.be_flag = 1'b1;
    end
    if (all_empty) begin
      n.irq = 1'b0;
    end else if (sync_mode_i ? en_full : (r.rcv_cnt == SLOT_W'(NSLOT))) begin
      n.irq = 1'b1;
    end
    if (init_take) begin
      if (!r.iph[init_fc]) begin
        n.iid[init_fc] = pl[NIB_LSB +: 4];
        n.iext[init_fc] = pl[EXT_LSB +: 6];
        n.iph[init_fc] = 1'b1;
      end else begin
        n.imem[init_fc][init_addr] = {r.iext[init_fc], pl[NIB_LSB +: 4], pl[EXT_LSB +: 6]};
        n.imap[init_fc][init_addr] = 1'b1;
        if (r.iid[init_fc] == 4'h2) begin
          n.iexp[init_fc][7:4] = pl[NIB_LSB +: 4];
        end
        if (r.iid[init_fc] == 4'h3) begin
          n.iexp[init_fc][3:0] = pl[NIB_LSB +: 4];
        end
        n.iph[init_fc] = 1'b0;
      end
    end
    n.idone = (&init_ok) && (r.imap != '0);
    n.irdy = r.idone && (other_ch_init_done_i || !other_ch_init_en_i);
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r <= RX_RST;
    end else if (clk_en_i) begin
      r <= n;
    end
  end

  assign rd_valid_o = r.rd_valid;
  assign rd_data_o = r.rd_data;
  assign buffer_empty_fault_flag_o = r.be_flag;
  assign global_status_o = r.be_flag;
  assign fifo_write_locked_flag_o = r.lock;
  assign irq_o = r.irq;
  assign init_done_o = r.idone;
  assign init_data_rdy_o = r.irdy;
  assign init_rd_data_o = r.ird;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  property p_rd_empty;
    logic [SLOT_W-1:0] k;
    (clk_en_i && r.st == ST_IDLE && rd_req_i && rd_idx_i < 3'h6 && !be_test_i, k = rd_idx_i)
      |=> r.sbuf[k] == EMPTY_WORD;
  endproperty
  a_rd_empty: assert property (p_rd_empty) else $error("read slot not cleared");

  property p_be_flag;
    clk_en_i && r.st == ST_CHECK && r.sbuf[r.chk_idx] != EMPTY_WORD |=> r.be_flag && global_status_o;
  endproperty
  a_be_flag: assert property (p_be_flag) else $error("empty check fault not latched");

  property p_lock_set;
    clk_en_i && !sync_mode_i && r.st == ST_IDLE && rd_req_i && rd_idx_i < 3'h6
      && r.sbuf[rd_idx_i] != EMPTY_WORD |=> fifo_write_locked_flag_o;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("lock not set on async read");

  property p_locked_hold;
    clk_en_i && !sync_mode_i && r.lock && fire |=> r.sbuf[0] == $past(r.sbuf[0]);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked fifo accepted a write");

  property p_async_shift;
    clk_en_i && !sync_mode_i && !r.lock && fire && !ch_evt
      |=> r.sbuf[0] == $past(store_word) && r.sbuf[5] == $past(r.sbuf[4]);
  endproperty
  a_async_shift: assert property (p_async_shift) else $error("async shift wrong");

  property p_sync_slot;
    logic [SLOT_W-1:0] k;
    logic [WORD_W-1:0] w;
    (clk_en_i && sync_mode_i && fire && fr_slot < 3'h6, k = fr_slot, w = store_word) |=> r.sbuf[k] == w;
  endproperty
  a_sync_slot: assert property (p_sync_slot) else $error("sync slot not overwritten");

  property p_chan_all;
    clk_en_i && sync_mode_i && ch_evt && !fire && !rd_req_i
      |=> r.sbuf[0] == code_word(r.hold_code) && r.sbuf[5] == code_word(r.hold_code);
  endproperty
  a_chan_all: assert property (p_chan_all) else $error("channel fault not in all slots");

  property p_prio_ot;
    fire && ot_i |-> fr_rk == RK_DATA || store_word == {11'h000, 10'h1F1, 10'h000};
  endproperty
  a_prio_ot: assert property (p_prio_ot) else $error("over temperature code wrong");

  property p_irq_async;
    clk_en_i && !sync_mode_i && r.rcv_cnt == 3'h6 && !all_empty |=> irq_o;
  endproperty
  a_irq_async: assert property (p_irq_async) else $error("async interrupt missing");

  property p_irq_clr;
    clk_en_i && all_empty |=> !irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("interrupt not cleared when empty");

  c_irq: cover property (clk_en_i && !sync_mode_i && r.rcv_cnt == 3'h6 ##1 irq_o);
  c_lock: cover property (fifo_write_locked_flag_o && fire);
  c_be: cover property ($rose(buffer_empty_fault_flag_o));
  c_init: cover property ($rose(init_data_rdy_o));
endmodule // srb_rx_buffer

// ==== dv/srb_host_model.sv ====
`timescale 1ns/1ns
module srb_host_model
  import srb_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rd_valid_i,
  input wire logic [srb_pkg::WORD_W-1:0] rd_data_i,
  output logic rd_req_o,
  output logic [srb_pkg::SLOT_W-1:0] rd_idx_o
);
  initial begin
    rd_req_o = 1'b0;
    rd_idx_o = 3'h0;
  end

  // One read pulse, answer taken when rd_valid_i shows, then spacing for the check cycle
  task automatic read_slot(input logic [SLOT_W-1:0] idx, output logic [WORD_W-1:0] d, output logic tmo);
    int n;
    n = 0;
    rd_req_o = 1'b1;
    rd_idx_o = idx;
    @(posedge ref_clk_i);
    #1;
    rd_req_o = 1'b0;
    rd_idx_o = ~idx;
    while (rd_valid_i !== 1'b1 && n < 8) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    tmo = (rd_valid_i !== 1'b1);
    d = rd_data_i;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask
endmodule // srb_host_model

// ==== dv/sensor_receive_buffer_bench.sv ====
`timescale 1ns/1ns
module sensor_receive_buffer_bench;
  import srb_pkg::*;
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic clk_en_i = 1'b1;
  logic sync_mode = 1'b0, chk_sel = 1'b0, fv_valid = 1'b0, me = 1'b0, ce = 1'b0;
  logic [NSLOT-1:0] slot_en = 6'h3F;
  logic [WORD_W-1:0] fdata = '0;
  logic [SLOT_W-1:0] fslot = 3'h0;
  logic [5:0] cond = 6'h00;
  logic fs_read = 1'b0, be_test = 1'b0, be_read = 1'b0;
  logic init_en = 1'b0, f20 = 1'b0;
  logic oth_en = 1'b0, oth_done = 1'b0;
  logic [2:0] ibuf = 3'h0;
  logic [3:0] iaddr = 4'h3;
  wire logic frame_ready, rd_req, rd_valid, be_flag, gstat, lock, irq, idone, irdy;
  wire logic [SLOT_W-1:0] rd_idx;
  wire logic [WORD_W-1:0] rd_data;
  wire logic [INIT_W-1:0] idata;
  int err_count = 0;
  int compares = 0;
  logic [WORD_W-1:0] d;
  logic [9:0] codes [6] = '{FC_PHY, FC_PHY, FC_STB, FC_PHY, FC_PHY, FC_SYNC};

  always #5 ref_clk_i = ~ref_clk_i;

  srb_rx_buffer uut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en_i), .sync_mode_i(sync_mode),
    .check_in_device_select_i(chk_sel), .slot_enable_i(slot_en), .frame_valid_i(fv_valid),
    .frame_ready_o(frame_ready), .frame_data_i(fdata), .frame_slot_i(fslot), .frame_manch_err_i(me),
    .frame_check_err_i(ce), .ot_i(cond[5]), .stg_i(cond[4]), .stb_i(cond[3]), .leak_i(cond[2]),
    .open_i(cond[1]), .sync_uv_i(cond[0]), .fault_status_read_i(fs_read), .rd_req_i(rd_req),
    .rd_idx_i(rd_idx), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .be_test_i(be_test),
    .be_flag_read_i(be_read), .buffer_empty_fault_flag_o(be_flag), .global_status_o(gstat),
    .fifo_write_locked_flag_o(lock), .irq_o(irq), .init_capture_en_i(init_en), .frame20_i(f20),
    .other_ch_init_en_i(oth_en), .other_ch_init_done_i(oth_done), .init_done_o(idone),
    .init_data_rdy_o(irdy), .init_rd_buf_i(ibuf), .init_rd_addr_i(iaddr), .init_rd_data_o(idata));

  srb_host_model host (.ref_clk_i(ref_clk_i), .rd_valid_i(rd_valid), .rd_data_i(rd_data),
    .rd_req_o(rd_req), .rd_idx_o(rd_idx));

  function automatic logic [WORD_W-1:0] cw(input logic [9:0] c);
    return {11'h000, c, 10'h000};
  endfunction

  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  task automatic push(input logic [WORD_W-1:0] w, input logic [2:0] s, input logic m, input logic c);
    fv_valid = 1'b1;
    fdata = w;
    fslot = s;
    me = m;
    ce = c;
    while (frame_ready !== 1'b1) begin
      @(posedge ref_clk_i);
      #1;
    end
    @(posedge ref_clk_i);
    #1;
    fv_valid = 1'b0;
    fdata = ~w;
    me = 1'b0;
    ce = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic rd(input logic [2:0] idx, input logic [WORD_W-1:0] exp);
    logic [WORD_W-1:0] v;
    logic t;
    host.read_slot(idx, v, t);
    // A missing answer counts as a mismatch
    if (t) v = ~exp;
    chk(v, exp);
  endtask

  task automatic wt(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask

  // Init word appears one cycle after the address is set
  task automatic iread(input logic [2:0] b, input logic [3:0] a, input logic [INIT_W-1:0] exp);
    ibuf = b;
    iaddr = a;
    wt(2);
    chk({15'h0, idata}, {15'h0, exp});
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    @(posedge ref_clk_i);
    #1;
    s = 1'b0;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  task automatic end_sim;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    err_count++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    nrst_i = 1'b1;
    chk({15'h0, idata}, '0);
    chk({30'h0, frame_ready}, 31'h1);
    rd(3'h5, EMPTY_WORD);
    for (int i = 1; i <= 7; i++) push({3'h0, 28'h0001000 + 28'(i)}, 3'h0, 1'b0, 1'b0);
    chk({30'h0, irq}, 31'h1);
    rd(3'h0, 31'h0001007);
    chk({30'h0, lock}, 31'h1);
    rd(3'h0, EMPTY_WORD);
    push(31'h0001234, 3'h0, 1'b0, 1'b0);
    for (int i = 1; i < 6; i++) rd(3'(i), 31'h0001007 - 31'(i));
    chk({29'h0, lock, irq}, 31'h0);
    push(31'h0000055, 3'h0, 1'b1, 1'b0);
    push(31'h500000AA, 3'h0, 1'b0, 1'b1);
    chk_sel = 1'b1;
    push(31'h500000BB, 3'h0, 1'b0, 1'b1);
    push(31'h70000ABC, 3'h0, 1'b0, 1'b0);
    rd(3'h0, 31'h0000ABC);
    rd(3'h1, cw(FC_CRC));
    rd(3'h2, 31'h500000AA);
    rd(3'h3, cw(FC_MANCH));
    // Battery short outranks open load, pushed once
    cond = 6'h0A;
    wt(3);
    cond = 6'h00;
    pulse(fs_read);
    rd(3'h1, EMPTY_WORD);
    rd(3'h0, cw(FC_STB));
    sync_mode = 1'b1;
    push(31'h0000A01, 3'h2, 1'b0, 1'b0);
    push(31'h0000B02, 3'h2, 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) if (i != 2) push(31'h0000C00 + 31'(i), 3'(i), 1'b0, 1'b0);
    chk({30'h0, irq}, 31'h1);
    rd(3'h2, 31'h0000B02);
    cond = 6'h28;
    wt(3);
    rd(3'h3, cw(FC_PHY));
    rd(3'h5, cw(FC_PHY));
    cond = 6'h00;
    pulse(fs_read);
    for (int i = 0; i < 6; i++) begin
      cond = 6'h20 >> i;
      wt(3);
      rd(3'h0, cw(codes[i]));
      cond = 6'h00;
      pulse(fs_read);
    end
    push(31'h0000D0D, 3'h0, 1'b0, 1'b0);
    be_test = 1'b1;
    rd(3'h0, 31'h0000D0D);
    be_test = 1'b0;
    chk({29'h0, be_flag, gstat}, 31'h3);
    pulse(be_read);
    chk({29'h0, be_flag, gstat}, 31'h0);
    // Frozen clock enable must drop the offered frame
    clk_en_i = 1'b0;
    push(31'h0000E0E, 3'h1, 1'b0, 1'b0);
    clk_en_i = 1'b1;
    wt(3);
    rd(3'h1, cw(FC_SYNC));
    // Init frames go to slot 7 so the slots stay untouched
    init_en = 1'b1;
    f20 = 1'b1;
    push(31'h000C0001, 3'h7, 1'b0, 1'b0);
    push(31'h000C0009, 3'h7, 1'b0, 1'b0);
    push(31'h00050001, 3'h7, 1'b0, 1'b0);
    push(31'h00050009, 3'h7, 1'b0, 1'b0);
    iread(3'h6, 4'h0, 16'h0000);
    iread(3'h2, 4'h0, 16'h0000);
    oth_en = 1'b1;
    push(31'h000202A1, 3'h7, 1'b0, 1'b0);
    push(31'h00020155, 3'h7, 1'b0, 1'b0);
    push(31'h00020002, 3'h7, 1'b0, 1'b0);
    push(31'h00020000, 3'h7, 1'b0, 1'b0);
    push(31'h00020003, 3'h7, 1'b0, 1'b0);
    chk({29'h0, idone, irdy}, 31'h0);
    push(31'h00020003, 3'h7, 1'b0, 1'b0);
    chk({29'h0, idone, irdy}, 31'h2);
    oth_done = 1'b1;
    wt(2);
    chk({29'h0, idone, irdy}, 31'h3);
    iread(3'h1, 4'h0, 16'hA955);
    iread(3'h1, 4'h2, 16'h00C0);
    nrst_i = 1'b0;
    wt(2);
    nrst_i = 1'b1;
    wt(2);
    chk({29'h0, idone, irdy}, 31'h0);
    iread(3'h1, 4'h0, 16'h0000);
    end_sim();
  end
endmodule // sensor_receive_buffer_bench
